// ---- hdl/abu_pkg.sv ----
// package of constants for the address breakpoint unit
package abu_pkg;
  // register byte offsets (printed offsets, byte addresses)
  localparam logic [15:0] ABU_OFS_WAIT_STATUS = 16'hFE00;
  localparam logic [15:0] ABU_OFS_RESERVED = 16'hFE02;
  localparam logic [15:0] ABU_OFS_FLAG_CONTROL = 16'hFE03;
  localparam logic [15:0] ABU_OFS_ADDR_HIGH = 16'hFE09;
  localparam logic [15:0] ABU_OFS_ADDR_LOW = 16'hFE0A;
  localparam logic [15:0] ABU_OFS_STATUS_CONTROL = 16'hFE0B;
  // field positions
  localparam int ABU_BIT_MATCH_ENABLE = 7;
  localparam int ABU_BIT_BREAK_ACTIVE = 6;
  localparam int ABU_BIT_FLAG_CLEAR = 7;
  localparam int ABU_BIT_WAIT_EXIT = 1;
  // reset values
  localparam logic [7:0] ABU_RST_BYTE = 8'h00;
  // vectors driven toward the core on a break
  localparam logic [15:0] ABU_VEC_NORMAL = 16'hFFFC;
  localparam logic [15:0] ABU_VEC_MONITOR = 16'hFEFC;
  // axi response codes
  localparam logic [1:0] ABU_RESP_OKAY = 2'h0;
  localparam logic [1:0] ABU_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ABU_IDLE,
    ABU_WAIT_BOUNDARY,
    ABU_IN_BREAK
  } abu_state_t;
endpackage : abu_pkg

// ---- hdl/abu_breakpoint.sv ----
// address breakpoint unit with axi4-lite register slave
// Operation
// - enabled break and pc address equals 16-bit break address raises request
// - break forces interrupt opcode, vector FFFC or FEFC in monitor mode
// - writing one to break-active bit itself raises a break (here only if the bit was zero and no break is pending)
// - break-active bit sets on a match, readable and writable
// - match enable at bit 7, read/write, reset clear, gates matches
// - opcode match: break before that instruction executes
// - operand match: instruction completes before the break
// - software break taken just before next instruction starts
// - return-from-interrupt in break routine ends the break state
// - same address after clear gives no further break after return
// - in break, flags clearable only when flag-clear enable set
// - timer counter halted while break in progress
// - watchdog disabled in break while test high voltage present
// - wait-exit bit 1 cleared by writing zero, resets to zero
// - wait-exit bit reads one when wait left by a break
// - no address-match break in wait or stop modes
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module abu_breakpoint
  import abu_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address, data and response
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // cpu side
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_addr_valid,
  input wire logic cpu_opcode_fetch,
  input wire logic cpu_instr_boundary,
  input wire logic cpu_rti_done,
  input wire logic cpu_low_power,
  input wire logic cpu_wait_exit,
  input wire logic monitor_mode,
  input wire logic test_high_voltage,
  // toward system integration unit and peer modules
  output logic breakpoint_request,
  output logic [15:0] break_vector,
  output logic break_state,
  output logic flag_clear_allowed,
  output logic timer_halt,
  output logic watchdog_disable
);
  if (ADDR_W != 16) begin : g_addr_w_check
    $error("abu_breakpoint: ADDR_W must be 16");
  end

  logic [7:0] addr_hi_r, addr_hi_nxt, addr_lo_r, addr_lo_nxt;
  logic match_en_r, match_en_nxt, active_r, active_nxt;
  logic flag_clr_r, flag_clr_nxt, wait_exit_r, wait_exit_nxt;
  logic armed_r, armed_nxt;
  abu_state_t state_r, state_nxt;
  logic req_r, req_nxt, tmr_r, tmr_nxt, wdg_r, wdg_nxt, fca_r, fca_nxt;
  logic [15:0] vec_r, vec_nxt;
  logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [15:0] awa_r, awa_nxt;
  logic [7:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, arrdy_r, arrdy_nxt;
  logic do_wr, hit, sw_break;

  function automatic logic known_ofs(input logic [15:0] a);
    known_ofs = (a == ABU_OFS_WAIT_STATUS) || (a == ABU_OFS_RESERVED) ||
      (a == ABU_OFS_FLAG_CONTROL) || (a == ABU_OFS_ADDR_HIGH) ||
      (a == ABU_OFS_ADDR_LOW) || (a == ABU_OFS_STATUS_CONTROL);
  endfunction : known_ofs

  // bus slave: address and data taken in either order, answer after both
  always_comb begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    bv_nxt = bv_r;
    bresp_nxt = bresp_r;
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rresp_nxt = rresp_r;
    do_wr = 1'b0;
    if (s_axi_awvalid && !aw_r && !bv_r) begin
      aw_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_r && !bv_r) begin
      w_nxt = 1'b1;
      wd_nxt = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
    end
    // strobe off on lane 0 writes zero to the addressed register
    if (aw_r && w_r) begin
      do_wr = known_ofs(awa_r) && (awa_r != ABU_OFS_RESERVED);
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      bv_nxt = 1'b1;
      bresp_nxt = known_ofs(awa_r) ? ABU_RESP_OKAY : ABU_RESP_SLVERR;
    end
    if (bv_r && s_axi_bready) bv_nxt = 1'b0;
    if (s_axi_arvalid && !rv_r) begin
      rv_nxt = 1'b1;
      rresp_nxt = known_ofs(s_axi_araddr) ? ABU_RESP_OKAY : ABU_RESP_SLVERR;
      unique case (s_axi_araddr)
        ABU_OFS_WAIT_STATUS: rd_nxt = {6'h00, wait_exit_r, 1'b0};
        ABU_OFS_FLAG_CONTROL: rd_nxt = {flag_clr_r, 7'h00};
        ABU_OFS_ADDR_HIGH: rd_nxt = addr_hi_r;
        ABU_OFS_ADDR_LOW: rd_nxt = addr_lo_r;
        ABU_OFS_STATUS_CONTROL: rd_nxt = {match_en_r, active_r, 6'h00};
        default: rd_nxt = ABU_RST_BYTE;
      endcase
    end else if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
    // readies follow next state so the ports come straight from flops
    awrdy_nxt = !aw_nxt && !bv_nxt;
    wrdy_nxt = !w_nxt && !bv_nxt;
    arrdy_nxt = !rv_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awa_r <= 16'h0000;
      wd_r <= ABU_RST_BYTE;
      bv_r <= 1'b0;
      bresp_r <= ABU_RESP_OKAY;
      rv_r <= 1'b0;
      rd_r <= ABU_RST_BYTE;
      rresp_r <= ABU_RESP_OKAY;
      awrdy_r <= 1'b1;
      wrdy_r <= 1'b1;
      arrdy_r <= 1'b1;
    end else begin
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      bv_r <= bv_nxt;
      bresp_r <= bresp_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
      rresp_r <= rresp_nxt;
      awrdy_r <= awrdy_nxt;
      wrdy_r <= wrdy_nxt;
      arrdy_r <= arrdy_nxt;
    end
  end

  assign s_axi_awready = awrdy_r;
  assign s_axi_wready = wrdy_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arrdy_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rdata = {24'h000000, rd_r};
  assign s_axi_rresp = rresp_r;

  // match needs an enabled unit, a real cpu cycle and a moving address bus
  assign hit = match_en_r && armed_r && cpu_addr_valid &&
    !cpu_low_power &&
    (cpu_addr == {addr_hi_r, addr_lo_r});
  assign sw_break = do_wr && (awa_r == ABU_OFS_STATUS_CONTROL) &&
    wd_r[ABU_BIT_BREAK_ACTIVE] && !active_r;

  // registers and break sequencing
  always_comb begin
    addr_hi_nxt = addr_hi_r;
    addr_lo_nxt = addr_lo_r;
    match_en_nxt = match_en_r;
    active_nxt = active_r;
    flag_clr_nxt = flag_clr_r;
    wait_exit_nxt = wait_exit_r;
    armed_nxt = armed_r;
    state_nxt = state_r;
    if (do_wr) begin
      unique case (awa_r)
        ABU_OFS_ADDR_HIGH: begin
          addr_hi_nxt = wd_r;
          armed_nxt = 1'b1;
        end
        ABU_OFS_ADDR_LOW: begin
          addr_lo_nxt = wd_r;
          armed_nxt = 1'b1;
        end
        ABU_OFS_FLAG_CONTROL: flag_clr_nxt = wd_r[ABU_BIT_FLAG_CLEAR];
        ABU_OFS_STATUS_CONTROL: begin
          match_en_nxt = wd_r[ABU_BIT_MATCH_ENABLE];
          active_nxt = wd_r[ABU_BIT_BREAK_ACTIVE];
        end
        // only a zero clears; a one written leaves the flag as is
        ABU_OFS_WAIT_STATUS: if (!wd_r[ABU_BIT_WAIT_EXIT])
          wait_exit_nxt = 1'b0;
        default: ;
      endcase
    end
    // wait exit caused by a pending break sets the flag, set beats clear
    if (cpu_wait_exit && state_r != ABU_IDLE) wait_exit_nxt = 1'b1;
    unique case (state_r)
      ABU_IDLE: begin
        if (hit) begin
          active_nxt = 1'b1;
          // the address stays disarmed until software rewrites it
          armed_nxt = 1'b0;
          // opcode hit: break at once so that opcode never runs
          state_nxt = cpu_opcode_fetch ? ABU_IN_BREAK : ABU_WAIT_BOUNDARY;
        end else if (sw_break) begin
          state_nxt = ABU_WAIT_BOUNDARY;
        end
      end
      ABU_WAIT_BOUNDARY: if (cpu_instr_boundary) state_nxt = ABU_IN_BREAK;
      ABU_IN_BREAK: if (cpu_rti_done) state_nxt = ABU_IDLE;
      default: state_nxt = ABU_IDLE;
    endcase
  end

  always_comb begin
    req_nxt = (state_nxt != ABU_IDLE);
    vec_nxt = monitor_mode ? ABU_VEC_MONITOR : ABU_VEC_NORMAL;
    tmr_nxt = (state_nxt == ABU_IN_BREAK);
    wdg_nxt = (state_nxt == ABU_IN_BREAK) && test_high_voltage;
    fca_nxt = (state_nxt != ABU_IN_BREAK) || flag_clr_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_hi_r <= ABU_RST_BYTE;
      addr_lo_r <= ABU_RST_BYTE;
      match_en_r <= 1'b0;
      active_r <= 1'b0;
      flag_clr_r <= 1'b0;
      wait_exit_r <= 1'b0;
      armed_r <= 1'b1;
      state_r <= ABU_IDLE;
      req_r <= 1'b0;
      vec_r <= ABU_VEC_NORMAL;
      tmr_r <= 1'b0;
      wdg_r <= 1'b0;
      fca_r <= 1'b1;
    end else begin
      addr_hi_r <= addr_hi_nxt;
      addr_lo_r <= addr_lo_nxt;
      match_en_r <= match_en_nxt;
      active_r <= active_nxt;
      flag_clr_r <= flag_clr_nxt;
      wait_exit_r <= wait_exit_nxt;
      armed_r <= armed_nxt;
      state_r <= state_nxt;
      req_r <= req_nxt;
      vec_r <= vec_nxt;
      tmr_r <= tmr_nxt;
      wdg_r <= wdg_nxt;
      fca_r <= fca_nxt;
    end
  end

  assign breakpoint_request = req_r;
  assign break_vector = vec_r;
  assign break_state = tmr_r;
  assign timer_halt = tmr_r;
  assign watchdog_disable = wdg_r;
  assign flag_clear_allowed = fca_r;

  chk_match_raises_req: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ABU_IDLE && hit |=> breakpoint_request && active_r)
    else $error("address match did not raise the request");
  chk_disabled_no_req: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ABU_IDLE && !sw_break && !(cpu_addr_valid && match_en_r)
    |=> !breakpoint_request)
    else $error("request raised without enable or write");
  chk_low_power_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ABU_IDLE && cpu_low_power && !sw_break |=> !breakpoint_request)
    else $error("request raised in low power mode");
  chk_sw_break_req: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ABU_IDLE && sw_break |=> breakpoint_request && active_r)
    else $error("software break did not raise the request");
  chk_opcode_immediate: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ABU_IDLE && hit && cpu_opcode_fetch |=> timer_halt)
    else $error("opcode match did not enter break at once");
  chk_rti_ends_break: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ABU_IN_BREAK && cpu_rti_done |=> !breakpoint_request [*2])
    else $error("return did not end the break");
  chk_vector_select: assert property (@(posedge aclk) disable iff (!aresetn)
    monitor_mode |=> break_vector == ABU_VEC_MONITOR)
    else $error("wrong break vector");
  chk_watchdog_off: assert property (@(posedge aclk) disable iff (!aresetn)
    watchdog_disable |-> timer_halt && $past(test_high_voltage))
    else $error("watchdog disabled outside a break");
  chk_no_rebreak: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ABU_IDLE && $past(state_r) == ABU_IN_BREAK && !do_wr
    && !$past(do_wr) |-> !hit)
    else $error("same address broke again");
endmodule : abu_breakpoint

// ---- verif/abu_cpu_model.sv ----
// behavioural cpu core and system integration unit facing the unit
`timescale 1ns/100ps
module abu_cpu_model (
  // clock, reset and bench control
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [15:0] start_pc,
  // from the breakpoint unit
  input wire logic breakpoint_request,
  input wire logic break_state,
  // cpu side
  output logic [15:0] cpu_addr,
  output logic cpu_addr_valid,
  output logic cpu_opcode_fetch,
  output logic cpu_instr_boundary,
  output logic cpu_rti_done
);
  logic [15:0] pc_r;
  logic [4:0] cnt_r;
  // an idle bus shows the inverse so a stale address never matches
  assign cpu_addr = cpu_addr_valid ? pc_r : ~pc_r;
  assign cpu_opcode_fetch = cpu_addr_valid && !pc_r[0];
  always_ff @(posedge aclk) begin
    cpu_instr_boundary <= 1'b0;
    cpu_rti_done <= 1'b0;
    if (!aresetn) begin
      pc_r <= start_pc;
      cpu_addr_valid <= 1'b0;
      cnt_r <= 5'h00;
    end else if (break_state) begin
      // long routine leaves software time to service registers
      cpu_addr_valid <= 1'b0;
      cnt_r <= cnt_r + 5'h01;
      cpu_rti_done <= (cnt_r == 5'h1F);
    end else if (breakpoint_request) begin
      cpu_addr_valid <= 1'b0;
      cnt_r <= 5'h00;
      cpu_instr_boundary <= !cpu_instr_boundary;
    end else if (!run) begin
      pc_r <= start_pc;
      cpu_addr_valid <= 1'b0;
    end else begin
      cpu_addr_valid <= 1'b1;
      if (cpu_addr_valid) pc_r <= pc_r + 16'h0001;
    end
  end
endmodule : abu_cpu_model

// ---- verif/address_breakpoint_unit_tb.sv ----
// self-checking bench for the address breakpoint unit
`timescale 1ns/100ps
module address_breakpoint_unit_tb;
  import abu_pkg::*;
  typedef struct packed {
    logic [15:0] a;
    logic [7:0] w;
    logic [7:0] d;
    logic [1:0] r;
  } abu_row_t;
  localparam logic [1:0] rok = ABU_RESP_OKAY;
  localparam logic [15:0] sc = ABU_OFS_STATUS_CONTROL;
  localparam logic [15:0] lo = ABU_OFS_ADDR_LOW;
  localparam logic [15:0] ws = ABU_OFS_WAIT_STATUS;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, cpu_addr_valid, cpu_opcode_fetch;
  logic cpu_instr_boundary, cpu_rti_done, cpu_low_power, cpu_wait_exit;
  logic monitor_mode, test_high_voltage, breakpoint_request, break_state;
  logic flag_clear_allowed, timer_halt, watchdog_disable, run;
  logic [15:0] s_axi_awaddr, s_axi_araddr, cpu_addr, break_vector, start_pc;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int mismatches = 0;
  int n_checks = 0;
  abu_row_t rows [7] = '{
    '{ABU_OFS_ADDR_HIGH, 8'hA5, 8'hA5, rok},
    '{lo, 8'h5A, 8'h5A, rok},
    '{ABU_OFS_FLAG_CONTROL, 8'hFF, 8'h80, rok},
    '{sc, 8'h80, 8'h80, rok},
    '{sc, 8'h3F, 8'h00, rok},
    '{ws, 8'hFF, 8'h00, rok},
    '{16'hFE04, 8'h12, 8'h00, ABU_RESP_SLVERR}
  };
  logic [15:0] regs [5] = '{ws, ABU_OFS_FLAG_CONTROL, ABU_OFS_ADDR_HIGH,
    lo, sc};

  always #5 aclk = ~aclk;

  abu_breakpoint DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_addr, .cpu_addr_valid,
    .cpu_opcode_fetch, .cpu_instr_boundary, .cpu_rti_done,
    .cpu_low_power, .cpu_wait_exit, .monitor_mode, .test_high_voltage,
    .breakpoint_request, .break_vector, .break_state,
    .flag_clear_allowed, .timer_halt, .watchdog_disable
  );
  abu_cpu_model cpu_m (
    .aclk, .aresetn, .run, .start_pc, .breakpoint_request, .break_state,
    .cpu_addr, .cpu_addr_valid, .cpu_opcode_fetch, .cpu_instr_boundary,
    .cpu_rti_done
  );

  task automatic chk_val(input logic [31:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : chk_val

  task automatic chk_bit(input logic g, e, input string m);
    chk_val(32'(g), 32'(e), m);
  endtask : chk_bit

  task automatic axw(input logic [15:0] a, input logic [7:0] d,
                     input logic [1:0] er = rok);
    int t = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 50);
    s_axi_bready <= 1'b0;
    chk_bit(s_axi_bvalid, 1'b1, "write answer");
    chk_val(32'(s_axi_bresp), 32'(er), "bresp");
  endtask : axw

  task automatic axr(input logic [15:0] a, input logic [7:0] d,
                     input logic [1:0] er = rok);
    int t = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 50);
    s_axi_rready <= 1'b0;
    chk_bit(s_axi_rvalid, 1'b1, "read answer");
    chk_val(s_axi_rdata, {24'h000000, d}, "rdata");
    chk_val(32'(s_axi_rresp), 32'(er), "rresp");
  endtask : axr

  // st selects break_state, otherwise breakpoint_request
  task automatic wait_sig(input logic st, input logic v);
    int t = 0;
    do begin
      @(posedge aclk);
      t++;
    end while ((st ? break_state : breakpoint_request) !== v && t < 100);
    chk_bit(st ? break_state : breakpoint_request, v, "break wait");
  endtask : wait_sig

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    #100000;
    mismatches++;
    $display("mismatch %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, cpu_low_power, cpu_wait_exit} = 4'h0;
    {monitor_mode, run, test_high_voltage} = 3'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    start_pc = 16'h1230;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      axw(rows[i].a, rows[i].w, rows[i].r);
      axr(rows[i].a, rows[i].d, rows[i].r);
    end
    axw(ABU_OFS_FLAG_CONTROL, 8'h00);
    axw(ABU_OFS_ADDR_HIGH, 8'h12);
    axw(lo, 8'h34);
    axw(sc, 8'h80);
    run <= 1'b1;
    wait_sig(1'b0, 1'b1);
    chk_bit(break_state, 1'b1, "opcode stop");
    chk_val(32'(break_vector), 32'(ABU_VEC_NORMAL), "vector");
    chk_bit(timer_halt, 1'b1, "timer");
    chk_bit(watchdog_disable, 1'b1, "wdog");
    chk_bit(flag_clear_allowed, 1'b0, "flags");
    axr(sc, 8'hC0);
    axw(sc, 8'h80);
    wait_sig(1'b1, 1'b0);
    run <= 1'b0;
    @(posedge aclk);
    run <= 1'b1;
    repeat (20) @(posedge aclk);
    chk_bit(breakpoint_request, 1'b0, "no rebreak");
    run <= 1'b0;
    cpu_low_power <= 1'b1;
    axw(lo, 8'h41);
    run <= 1'b1;
    repeat (40) @(posedge aclk);
    chk_bit(breakpoint_request, 1'b0, "low power");
    cpu_low_power <= 1'b0;
    run <= 1'b0;
    @(posedge aclk);
    run <= 1'b1;
    wait_sig(1'b0, 1'b1);
    chk_bit(break_state, 1'b0, "operand");
    wait_sig(1'b1, 1'b1);
    axw(sc, 8'h80);
    wait_sig(1'b1, 1'b0);
    run <= 1'b0;
    start_pc <= 16'hEDBE;
    axw(lo, 8'h41);
    repeat (20) @(posedge aclk);
    chk_bit(breakpoint_request, 1'b0, "idle bus");
    monitor_mode <= 1'b1;
    test_high_voltage <= 1'b0;
    axw(ABU_OFS_FLAG_CONTROL, 8'h80);
    axw(sc, 8'hC0);
    wait_sig(1'b0, 1'b1);
    cpu_wait_exit <= 1'b1;
    chk_val(32'(break_vector), 32'(ABU_VEC_MONITOR), "mon");
    @(posedge aclk);
    cpu_wait_exit <= 1'b0;
    wait_sig(1'b1, 1'b1);
    chk_bit(flag_clear_allowed, 1'b1, "flags");
    chk_bit(watchdog_disable, 1'b0, "wdog");
    axr(ws, 8'h02);
    axw(ws, 8'h00);
    axr(ws, 8'h00);
    axw(sc, 8'h80);
    wait_sig(1'b1, 1'b0);
    monitor_mode <= 1'b0;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk_val(32'(break_vector), 32'(ABU_VEC_NORMAL), "rst vec");
    chk_bit(flag_clear_allowed, 1'b1, "rst flags");
    aresetn <= 1'b1;
    foreach (regs[i]) axr(regs[i], ABU_RST_BYTE);
    final_report();
  end
endmodule : address_breakpoint_unit_tb
